// ==== hw/polc_top.sv ====
// top of the parallel optic link control block with wishbone slave
// assumes pins are asynchronous; lane data already in this clock
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module polc_top
#(
  parameter int NL = polc_pkg::LANES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [polc_pkg::AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // transmit control pins
  input wire logic transmit_allow,
  input wire logic transmit_inhibit,
  input wire logic laser_clear_n,
  input wire logic laser_fault,
  input wire logic [NL-1:0] tx_lane_in,
  output logic [NL-1:0] tx_lane_out,
  output logic laser_health,
  // receive pins
  input wire logic rx_output_gate,
  input wire logic [NL-1:0] lane_light,
  input wire logic [NL-1:0] rx_lane_in,
  output logic [NL-1:0] rx_lane_out,
  output logic all_lanes_light_ok,
  output logic first_lane_light_ok,
  output logic last_lane_light_ok_n,
  // interrupt
  output logic irq
);
  import polc_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic allowS, inhibitS, clearS, faultS, gateS;
  logic [NL-1:0] lightS;
  polc_sync #(.RST_VAL(1'b1)) uAllow (.clock(clock), .nrst(nrst),
    .pinIn(transmit_allow), .syncOut(allowS));
  polc_sync #(.RST_VAL(1'b0)) uInh (.clock(clock), .nrst(nrst),
    .pinIn(transmit_inhibit), .syncOut(inhibitS));
  polc_sync #(.RST_VAL(1'b0)) uClr (.clock(clock), .nrst(nrst),
    .pinIn(laser_clear_n), .syncOut(clearS));
  polc_sync #(.RST_VAL(1'b0)) uFlt (.clock(clock), .nrst(nrst),
    .pinIn(laser_fault), .syncOut(faultS));
  polc_sync #(.RST_VAL(1'b0)) uGate (.clock(clock), .nrst(nrst),
    .pinIn(rx_output_gate), .syncOut(gateS));
  genvar gi;
  generate
    // each lane is independent, no shared framing [R12]
    for (gi = 0; gi < NL; gi++) begin : gLight
      polc_sync #(.RST_VAL(1'b0)) uL (.clock(clock), .nrst(nrst),
        .pinIn(lane_light[gi]), .syncOut(lightS[gi])); // [R14]
    end
  endgenerate

  // ****************************************
  // register file
  // ****************************************
  logic [31:0] ctrl_q, ctrl_d;
  logic [EVW-1:0] irqSt_q, irqSt_d;
  logic [EVW-1:0] evt;
  wire sel = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire hitCtrl = wb_adr_i == OFS_CTRL;
  wire hitStat = wb_adr_i == OFS_STAT;
  wire hitIrqs = wb_adr_i == OFS_IRQS;
  wire hitIrqc = wb_adr_i == OFS_IRQC;
  wire mapped = hitCtrl | hitStat | hitIrqs | hitIrqc;
  wire wrCtrl = sel & wb_we_i & hitCtrl;
  wire wrClr = sel & wb_we_i & hitIrqc;
  wire [31:0] selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [EVW-1:0] clrBits = wrClr ? (wb_dat_i[EVW-1:0] & selMask[EVW-1:0])
    : '0;
  assign ctrl_d = wrCtrl ? ((ctrl_q & ~selMask) | (wb_dat_i & selMask))
    : ctrl_q;
  // set wins over clear
  assign irqSt_d = (irqSt_q & ~clrBits) | evt;

  // ****************************************
  // transmit control
  // ****************************************
  // software levels combine with pin levels
  wire allowAll = allowS & ctrl_q[CTRL_ALLOW];
  wire inhibitAny = inhibitS | ctrl_q[CTRL_INHIBIT];
  wire clearAll = clearS & ctrl_q[CTRL_CLEARN];
  wire laserOk = clearAll & ~faultS; // [R4] [R5]
  wire txRun = allowAll & ~inhibitAny & laserOk; // [R1] [R2]
  wire [NL-1:0] txNext = txRun ? tx_lane_in : '0; // [R2]
  wire rxGate = gateS & ~ctrl_q[CTRL_GATE];

  // ****************************************
  // receive detect
  // ****************************************
  wire allOk = &lightS; // [R8] [R11]
  wire firstOk = lightS[0]; // [R9]
  wire lastOkN = ~lightS[NL-1]; // [R9]
  logic allOkPrev_q, faultPrev_q, clearPrev_q;
  assign evt[EV_FAULT] = faultS & ~faultPrev_q;
  assign evt[EV_LOSS] = ~allOk & allOkPrev_q;
  assign evt[EV_GAIN] = allOk & ~allOkPrev_q;
  assign evt[EV_CLEAR] = ~clearAll & clearPrev_q;
  wire [EVW-1:0] irqEn = ctrl_q[IEN_LSB +: EVW];
  wire [31:0] statWord = {27'h0, txRun, lastOkN, firstOk, allOk, laserOk};
  wire [31:0] rdData = hitCtrl ? ctrl_q :
    hitStat ? statWord :
    hitIrqs ? {{(32-EVW){1'b0}}, irqSt_q} : 32'h0000_0000;

  generate
    for (gi = 0; gi < NL; gi++) begin : gRx
      polc_lane_gate uG (.clock(clock), .nrst(nrst), .gate(rxGate),
        .laneIn(rx_lane_in[gi]), .laneOut(rx_lane_out[gi])); // [R10]
    end
  endgenerate

  // ****************************************
  // state
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      irqSt_q <= '0;
      allOkPrev_q <= 1'b0;
      faultPrev_q <= 1'b0;
      clearPrev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irqSt_q <= irqSt_d;
      allOkPrev_q <= allOk;
      faultPrev_q <= faultS;
      clearPrev_q <= clearAll;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= sel & mapped;
      wb_err_o <= sel & ~mapped;
      wb_dat_o <= (sel & ~wb_we_i) ? rdData : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_lane_out <= '0;
      laser_health <= 1'b0;
      all_lanes_light_ok <= 1'b0;
      first_lane_light_ok <= 1'b0;
      last_lane_light_ok_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      tx_lane_out <= txNext; // [R1] [R2] [R4] [R5]
      laser_health <= laserOk; // [R4] [R6]
      all_lanes_light_ok <= allOk; // [R8]
      first_lane_light_ok <= firstOk; // [R9]
      last_lane_light_ok_n <= lastOkN; // [R9] [R11]
      irq <= |(irqSt_d & irqEn);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_tx_off: assert property (@(posedge clock) disable iff (!nrst) // [R2]
    (!allowAll || inhibitAny) |=> tx_lane_out == '0)
    else $error("tx lanes not off");
  a_tx_run: assert property (@(posedge clock) disable iff (!nrst) // [R1]
    txRun |=> tx_lane_out == $past(tx_lane_in))
    else $error("tx lanes not passing data");
  a_fault_off: assert property (@(posedge clock) disable iff (!nrst) // [R4]
    faultS |=> !laser_health && tx_lane_out == '0)
    else $error("fault not shown");
  a_clear_off: assert property (@(posedge clock) disable iff (!nrst) // [R5]
    !clearAll |=> tx_lane_out == '0)
    else $error("clear did not stop lasers");
  a_clear_health: assert property (@(posedge clock) disable iff (!nrst) // [R6]
    (!clearAll)[*2] |=> !laser_health)
    else $error("health high during clear");
  a_all_detect: assert property (@(posedge clock) disable iff (!nrst) // [R8]
    ##1 all_lanes_light_ok == $past(&lightS))
    else $error("all lanes detect wrong");
  a_edge_detect: assert property (@(posedge clock) disable iff (!nrst) // [R9]
    ##1 (first_lane_light_ok == $past(lightS[0])) &&
    (last_lane_light_ok_n == !$past(lightS[NL-1])))
    else $error("edge lane detect wrong");
  a_rx_gate: assert property (@(posedge clock) disable iff (!nrst) // [R10]
    !rxGate |=> rx_lane_out == '0)
    else $error("rx outputs not forced low");
  a_detect_free: assert property (@(posedge clock) disable iff (!nrst) // [R11]
    (!rxGate && allOk) |=> all_lanes_light_ok)
    else $error("detect gated by rx gate");
  a_lanes_indep: assert property (@(posedge clock) disable iff (!nrst) // [R12]
    rxGate |=> rx_lane_out == $past(rx_lane_in))
    else $error("lane data mixed");
  a_light_input: assert property (@(posedge clock) disable iff (!nrst) // [R14]
    $rose(allOk) |=> all_lanes_light_ok ##0 irqSt_q[EV_GAIN])
    else $error("light event lost");

  // ****************************************
  // assertion sequences
  // ****************************************
  // a request taken while nothing is answered
  sequence s_wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  // one answer, ack or err, in the next cycle
  sequence s_wb_answer;
    ##1 (wb_ack_o ^ wb_err_o);
  endsequence
  // synced fault pin rising
  sequence s_fault_rise;
    !faultS ##1 faultS;
  endsequence
  // lit lanes losing light
  sequence s_light_loss;
    allOk ##1 !allOk;
  endsequence
  // laser clear going active
  sequence s_clear_fall;
    clearAll ##1 !clearAll;
  endsequence
  // laser clear released
  sequence s_clear_release;
    !clearAll ##1 clearAll;
  endsequence

  // ****************************************
  // bus and interrupt assertions
  // ****************************************
  a_wb_answer: assert property (@(posedge clock) disable iff (!nrst)
    s_wb_take |-> s_wb_answer)
    else $error("bus request not answered once");
  a_wb_kind: assert property (@(posedge clock) disable iff (!nrst)
    (s_wb_take ##0 !mapped) |=> wb_err_o)
    else $error("unmapped request without err");
  a_ack_pulse: assert property (@(posedge clock) disable iff (!nrst)
    (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o))
    else $error("bus answer longer than one cycle");
  a_ack_excl: assert property (@(posedge clock) disable iff (!nrst)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_dat_idle: assert property (@(posedge clock) disable iff (!nrst)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_ctrl_write: assert property (@(posedge clock) disable iff (!nrst)
    (s_wb_take ##0 (wb_we_i && hitCtrl && wb_sel_i == 4'hF)) |=>
    ctrl_q == $past(wb_dat_i))
    else $error("control write lost");
  a_ro_ignored: assert property (@(posedge clock) disable iff (!nrst)
    (s_wb_take ##0 (wb_we_i && !hitCtrl)) |=> ctrl_q == $past(ctrl_q))
    else $error("control changed by other write");
  a_set_wins: assert property (@(posedge clock) disable iff (!nrst)
    (evt != '0) |=> (irqSt_q & $past(evt)) == $past(evt))
    else $error("event not kept in status");
  a_clear_bits: assert property (@(posedge clock) disable iff (!nrst)
    (wrClr && evt == '0) |=> (irqSt_q & $past(clrBits)) == '0)
    else $error("status bit not cleared");
  a_sticky_hold: assert property (@(posedge clock) disable iff (!nrst)
    (!wrClr && evt == '0) |=> irqSt_q == $past(irqSt_q))
    else $error("status bit not sticky");
  a_irq_level: assert property (@(posedge clock) disable iff (!nrst)
    ##1 irq == |(irqSt_q & $past(irqEn)))
    else $error("irq level wrong");

  // ****************************************
  // transmit and receive assertions
  // ****************************************
  a_health_back: assert property (@(posedge clock) disable iff (!nrst) // [R4]
    laserOk |=> laser_health)
    else $error("health low while lasers fine");
  a_fault_event: assert property (@(posedge clock) disable iff (!nrst) // [R4]
    s_fault_rise |=> irqSt_q[EV_FAULT])
    else $error("fault event lost");
  a_clear_event: assert property (@(posedge clock) disable iff (!nrst) // [R5]
    s_clear_fall |=> irqSt_q[EV_CLEAR])
    else $error("clear event lost");
  a_clear_run: assert property (@(posedge clock) disable iff (!nrst) // [R5]
    (s_clear_release ##0 !faultS) |=> laser_health)
    else $error("lasers not back after clear");
  a_pin_inhibit: assert property (@(posedge clock) disable iff (!nrst) // [R2]
    inhibitS |=> tx_lane_out == '0)
    else $error("inhibit pin did not stop lanes");
  a_pin_allow: assert property (@(posedge clock) disable iff (!nrst) // [R2]
    !allowS |=> tx_lane_out == '0)
    else $error("allow pin low did not stop lanes");
  a_loss_event: assert property (@(posedge clock) disable iff (!nrst) // [R8]
    s_light_loss |=> irqSt_q[EV_LOSS])
    else $error("light loss event lost");
  a_detect_low: assert property (@(posedge clock) disable iff (!nrst) // [R11]
    (!rxGate && !allOk) |=> !all_lanes_light_ok)
    else $error("detect high without light");
endmodule // polc_top

// ==== hw/polc_pkg.sv ====
// package of constants for the parallel optic link control block
// assumes a wishbone classic master with 32-bit data on one clock
//
// Functional notes
// [R1] lanes run only while allow is high and inhibit is low
// [R2] allow low or inhibit high turns every transmit lane off
// [R3] host drives allow and inhibit to proper levels for normal use
// [R4] health high when fine; laser fault drives it low, lasers off
// [R5] laser clear low holds laser circuitry in reset, lasers off
// [R6] health stays low for as long as laser clear is low
// [R7] host keeps laser clear low until supply reaches minimum voltage
// [R8] all-lanes detect high only when all twelve lanes see light
// [R9] first lane detect active high, last lane detect active low
// [R10] rx gate low forces every lane output to zero
// [R11] detect outputs work whatever the rx gate level
// [R12] twelve lanes independent, no shared clock or framing
// [R13] host sends only dc balanced data on each lane
// [R14] lane light condition is an abstract boolean input
package polc_pkg;
  localparam int LANES = 12;
  localparam int AW = 4;
  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [AW-1:0] OFS_STAT = 4'h4;
  localparam logic [AW-1:0] OFS_IRQS = 4'h8;
  localparam logic [AW-1:0] OFS_IRQC = 4'hC;
  // control fields
  localparam int CTRL_ALLOW = 0;
  localparam int CTRL_INHIBIT = 1;
  localparam int CTRL_CLEARN = 2;
  localparam int CTRL_GATE = 3;
  localparam int IEN_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // status / irq fields
  localparam int ST_HEALTH = 0;
  localparam int ST_ALLOK = 1;
  localparam int ST_FIRST = 2;
  localparam int ST_LASTN = 3;
  localparam int ST_TXON = 4;
  localparam int EVW = 4;
  localparam int EV_FAULT = 0;
  localparam int EV_LOSS = 1;
  localparam int EV_GAIN = 2;
  localparam int EV_CLEAR = 3;
endpackage

// ==== hw/polc_sync.sv ====
// three-flop synchroniser with agreement of the last two stages
// assumes an asynchronous pin input
`timescale 1ns/1ps
module polc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // pin and result
  input wire logic pinIn,
  output logic syncOut
);
  logic s1_q, s2_q, s3_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) syncOut <= s3_q;
    end
  end
endmodule // polc_sync

// ==== hw/polc_lane_gate.sv ====
// one receive lane gated by the output gate
// assumes lane data sampled in the same clock
`timescale 1ns/1ps
module polc_lane_gate (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // lane
  input wire logic gate,
  input wire logic laneIn,
  output logic laneOut
);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) laneOut <= 1'b0;
    else laneOut <= gate & laneIn; // [R10]
  end
endmodule // polc_lane_gate

// ==== verification/polc_host_model.sv ====
// host board model: lane serializer and laser clear control
// assumes the bench raises supplyOk once the rail is up
`timescale 1ns/1ps
module polc_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bench requests
  input wire logic supplyOk,
  input wire logic clearReq,
  // pins to the block
  output logic laser_clear_n,
  output logic [11:0] tx_lane_in
);
  // clear kept low until the rail is up
  assign laser_clear_n = supplyOk & clearReq;
  // word and its inverse, six ones each: dc balanced
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_lane_in <= 12'hA5A;
    end else begin
      tx_lane_in <= ~tx_lane_in;
    end
  end
endmodule // polc_host_model

// ==== verification/parallel_optic_link_control_tb.sv ====
// self-checking bench for the optic link control block
// assumes polc_pkg and the design files compiled first
`timescale 1ns/1ps
module parallel_optic_link_control_tb;
  import polc_pkg::*;
  logic clock = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
  logic [AW-1:0] adr = '0;
  logic [31:0] wdat = '0, rdat, rd;
  logic ack, err, gotErr, allow = 1, inhibit = 0, fault = 0, gate = 1;
  logic supplyOk = 0, clearReq = 0, clearN, health, irq;
  logic allOk, firstOk, lastOkN;
  logic [11:0] lightIn = '0, rxIn = 12'h3C5, txIn, txOut, txPrev, rxOut;
  int n_fail = 0;
  int tests_run = 0;
  always #5 clock = ~clock;
  always @(posedge clock) txPrev <= txIn;
  polc_host_model host (.clock(clock), .nrst(nrst), .supplyOk(supplyOk),
    .clearReq(clearReq), .laser_clear_n(clearN), .tx_lane_in(txIn));
  polc_top DUT (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .transmit_allow(allow), .transmit_inhibit(inhibit),
    .laser_clear_n(clearN), .laser_fault(fault), .tx_lane_in(txIn),
    .tx_lane_out(txOut), .laser_health(health), .rx_output_gate(gate),
    .lane_light(lightIn), .rx_lane_in(rxIn), .rx_lane_out(rxOut),
    .all_lanes_light_ok(allOk), .first_lane_light_ok(firstOk),
    .last_lane_light_ok_n(lastOkN), .irq(irq));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle, held until ack or err is sampled
  task automatic wb(logic w, logic [AW-1:0] a, logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    rd = rdat;
    gotErr = err;
    if (n >= 20) begin
      chk("wb answer", 1, 0);
    end
    cyc <= 0;
    stb <= 0;
    @(posedge clock);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic t_run();
    wb(0, OFS_CTRL, 0);
    chk("ctrl reset", CTRL_RST, rd);
    chk("health held", 0, health);
    supplyOk <= 1;
    clearReq <= 1;
    wb(1, OFS_CTRL, 32'h0000_0005);
    tick(8);
    chk("health", 1, health);
    chk("tx lanes", txPrev, txOut);
    wb(0, OFS_STAT, 0);
    chk("stat", 5'h11, rd[4:0] & 5'h11);
  endtask
  task automatic t_off();
    for (int i = 0; i < 3; i++) begin
      allow <= (i != 0);
      inhibit <= (i == 1);
      if (i == 2) wb(1, OFS_CTRL, 32'h0000_0007);
      tick(8);
      chk("tx off", 0, txOut);
    end
    allow <= 1;
    inhibit <= 0;
    wb(1, OFS_CTRL, 32'h0000_0005);
    tick(8);
    chk("tx back", txPrev, txOut);
  endtask
  task automatic t_fault();
    wb(1, OFS_IRQC, 32'h0000_000F);
    fault <= 1;
    tick(8);
    chk("fault health", 0, health);
    chk("fault lanes", 0, txOut);
    chk("irq masked", 0, irq);
    wb(0, OFS_IRQS, 0);
    chk("irq status", 1, rd[EV_FAULT]);
    wb(1, OFS_CTRL, 32'h0000_0105);
    tick(2);
    chk("irq on", 1, irq);
    fault <= 0;
    wb(1, OFS_IRQC, 32'h0000_0001);
    tick(2);
    chk("irq cleared", 0, irq);
    clearReq <= 0;
    tick(8);
    chk("clear health", 0, health);
    chk("clear lanes", 0, txOut);
    clearReq <= 1;
    tick(8);
    chk("clear release", 1, health);
  endtask
  task automatic t_light();
    logic [11:0] pat [4] = '{12'hFFF, 12'hFDF, 12'h7FF, 12'hFFE};
    logic [2:0] exp [4] = '{3'b110, 3'b010, 3'b011, 3'b000};
    gate <= 0;
    for (int i = 0; i < 4; i++) begin
      lightIn <= pat[i];
      tick(8);
      chk("detect", exp[i], {allOk, firstOk, lastOkN});
      chk("rx gated", 0, rxOut);
    end
    wb(0, OFS_IRQS, 0);
    chk("irq events", 4'hE, rd[3:0]);
    gate <= 1;
    tick(8);
    chk("rx data", rxIn, rxOut);
    wb(1, OFS_CTRL, 32'h0000_010D);
    tick(2);
    chk("rx sw gate", 0, rxOut);
    wb(0, 4'h2, 0);
    chk("unmapped", 1, gotErr);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    t_run();
    t_off();
    t_fault();
    t_light();
    test_done();
  end
endmodule // parallel_optic_link_control_tb
